// >>> frt_pkg.sv
// package: register indices, field positions, reset values and counts of the timer block
package frt_pkg;
    localparam int FRT_AW = 3;
    localparam int FRT_DW = 8;
    // register indices (byte registers, one per address)
    localparam logic [2:0] FRT_REG_MASK2 = 3'h0;
    localparam logic [2:0] FRT_REG_FLAG2 = 3'h1;
    localparam logic [2:0] FRT_REG_TICK_CTL = 3'h2;
    localparam logic [2:0] FRT_REG_TEST = 3'h3;
    localparam logic [2:0] FRT_REG_CNT_HI = 3'h4;
    localparam logic [2:0] FRT_REG_CNT_LO = 3'h5;
    // field positions (mask and flag registers share the layout of bits 7 and 6)
    localparam int FRT_BIT_WRAP = 7;
    localparam int FRT_BIT_TICK = 6;
    localparam int FRT_BIT_BYPASS = 0;
    localparam int FRT_PR_LSB = 0;
    localparam int FRT_RTR_LSB = 0;
    localparam int FRT_CTL_HI_LSB = 4;
    // reset values
    localparam logic [7:0] FRT_RST_MASK2 = 8'h00;
    localparam logic [7:0] FRT_RST_TICK_CTL = 8'h00;
    localparam logic [15:0] FRT_RST_CNT = 16'h0000;
    // timing counts in bus clock cycles
    localparam int FRT_WIN_CYCLES = 64;
    localparam logic [6:0] FRT_WIN_LAST = 7'(FRT_WIN_CYCLES - 1);
    localparam int FRT_TAP_BITS = 13;
    localparam logic [15:0] FRT_CNT_MAX = 16'hFFFF;
    // prescale select codes
    typedef enum logic [1:0] {
        FRT_PR_DIV1 = 2'b00,
        FRT_PR_DIV4 = 2'b01,
        FRT_PR_DIV8 = 2'b10,
        FRT_PR_DIV16 = 2'b11
    } frt_pr_t;
endpackage

// >>> frt_timer.sv
// free-running 16-bit timer with prescaler, wrap flag and periodic tick
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Function
// - counter advances at bus clock divided by prescale factor 1, 4, 8 or 16
// - normal modes: one prescale write, first 64 cycles after reset only
// - wrap flag sets when counter rolls from all ones to zero
// - writing one to flag register bit 7 clears the wrap flag
// - counter keeps running whether or not the wrap flag was cleared
// - wrap enable gates the wrap interrupt request, never the flag itself
// - bypass clocks both counter halves every cycle, skipping the prescaler
// - bypass bit is writable only in special modes
// - tick source is bus clock divided by 2^13, independent of prescale
// - tick rate bits divide the tick source by 1, 2, 4 or 8
// - tick divider runs freely; periods timed from previous timeout
// - tick flag sets each period end; writing one to bit 6 clears it
// - tick enable gates the tick interrupt request, never the flag itself
// - tick flag holds until cleared, so interrupt re-requests at once
// - tick rate resets to fastest and may be changed at any time
// - control register resets to zero; bits 3 and 2 read zero
// - writing zero to a flag position leaves that flag alone
module frt_timer (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // operating mode
    input wire logic special_mode_i,
    // register port
    input wire logic [frt_pkg::FRT_AW-1:0] reg_addr_i,
    input wire logic [frt_pkg::FRT_DW-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [frt_pkg::FRT_DW-1:0] reg_rdata_o,
    // interrupt and counter
    output logic irq_o,
    output logic [15:0] count_o
);
    import frt_pkg::*;

    typedef struct packed {
        logic [15:0] cnt;
        logic [3:0] pre;
        logic [6:0] win;
        logic win_open;
        logic pr_written;
        logic [1:0] pr;
        logic wrap_ie;
        logic tick_ie;
        logic wrap_f;
        logic tick_f;
        logic [3:0] ctl_hi;
        logic [1:0] rtr;
        logic bypass;
        logic [FRT_TAP_BITS-1:0] tap;
        logic [2:0] tick_div;
        logic [7:0] rdata;
        logic irq;
    } frt_state_t;

    frt_state_t st_r;
    frt_state_t st_nxt;

    logic [3:0] pre_mask;
    logic [2:0] tick_mask;
    logic cnt_adv;
    logic wrap_evt;
    logic tap_evt;
    logic tick_evt;
    logic wr_mask2;
    logic wr_flag2;
    logic wr_tick_ctl;
    logic wr_test;

    always_comb begin
        // prescale factor expressed as a mask on the prescaler
        case (frt_pr_t'(st_r.pr))
            FRT_PR_DIV1: pre_mask = 4'h0;
            FRT_PR_DIV4: pre_mask = 4'h3;
            FRT_PR_DIV8: pre_mask = 4'h7;
            FRT_PR_DIV16: pre_mask = 4'hF;
            default: pre_mask = 4'h0;
        endcase
        case (st_r.rtr)
            2'b00: tick_mask = 3'h0;
            2'b01: tick_mask = 3'h1;
            2'b10: tick_mask = 3'h3;
            2'b11: tick_mask = 3'h7;
            default: tick_mask = 3'h0;
        endcase
    end

    always_comb begin
        wr_mask2 = reg_wr_i && (reg_addr_i == FRT_REG_MASK2);
        wr_flag2 = reg_wr_i && (reg_addr_i == FRT_REG_FLAG2);
        wr_tick_ctl = reg_wr_i && (reg_addr_i == FRT_REG_TICK_CTL);
        wr_test = reg_wr_i && (reg_addr_i == FRT_REG_TEST);
        // bypass advances on every cycle; otherwise prescaler terminal count
        cnt_adv = st_r.bypass || ((st_r.pre & pre_mask) == pre_mask);
        wrap_evt = cnt_adv && (st_r.cnt == FRT_CNT_MAX);
        // own divider on the bus clock, so prescale never shifts the tick rate
        tap_evt = &st_r.tap;
        tick_evt = tap_evt && ((st_r.tick_div & tick_mask) == tick_mask);
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.pre = st_r.pre + 4'h1;
        if (st_r.bypass) begin
            // halves count side by side, no carry between them
            st_nxt.cnt = {st_r.cnt[15:8] + 8'h01, st_r.cnt[7:0] + 8'h01};
        end else if (cnt_adv) begin
            st_nxt.cnt = st_r.cnt + 16'h0001;
        end
        st_nxt.tap = st_r.tap + 1'b1;
        if (tap_evt) begin
            st_nxt.tick_div = st_r.tick_div + 3'h1;
        end
        if (st_r.win_open) begin
            st_nxt.win = st_r.win + 7'h01;
            st_nxt.win_open = (st_r.win != FRT_WIN_LAST);
        end
        if (wr_mask2) begin
            st_nxt.wrap_ie = reg_wdata_i[FRT_BIT_WRAP];
            st_nxt.tick_ie = reg_wdata_i[FRT_BIT_TICK];
            if (special_mode_i) begin
                st_nxt.pr = reg_wdata_i[FRT_PR_LSB +: 2];
            end else if (st_r.win_open && !st_r.pr_written) begin
                st_nxt.pr = reg_wdata_i[FRT_PR_LSB +: 2];
                st_nxt.pr_written = 1'b1;
            end
        end
        if (wr_tick_ctl) begin
            st_nxt.ctl_hi = reg_wdata_i[FRT_CTL_HI_LSB +: 4];
            st_nxt.rtr = reg_wdata_i[FRT_RTR_LSB +: 2];
        end
        if (wr_test && special_mode_i) begin
            st_nxt.bypass = reg_wdata_i[FRT_BIT_BYPASS];
        end
        // a one clears, a zero is ignored, and a same-cycle event wins
        if (wr_flag2 && reg_wdata_i[FRT_BIT_WRAP]) begin
            st_nxt.wrap_f = 1'b0;
        end
        if (wr_flag2 && reg_wdata_i[FRT_BIT_TICK]) begin
            st_nxt.tick_f = 1'b0;
        end
        if (wrap_evt) begin
            st_nxt.wrap_f = 1'b1;
        end
        if (tick_evt) begin
            st_nxt.tick_f = 1'b1;
        end
        st_nxt.irq = (st_nxt.wrap_f && st_nxt.wrap_ie) ||
                     (st_nxt.tick_f && st_nxt.tick_ie);
        st_nxt.rdata = 8'h00;
        if (reg_rd_i) begin
            case (reg_addr_i)
                FRT_REG_MASK2: st_nxt.rdata = {st_r.wrap_ie, st_r.tick_ie, 4'h0, st_r.pr};
                FRT_REG_FLAG2: st_nxt.rdata = {st_r.wrap_f, st_r.tick_f, 6'h00};
                FRT_REG_TICK_CTL: st_nxt.rdata = {st_r.ctl_hi, 2'b00, st_r.rtr};
                FRT_REG_TEST: st_nxt.rdata = {7'h00, st_r.bypass};
                FRT_REG_CNT_HI: st_nxt.rdata = st_r.cnt[15:8];
                FRT_REG_CNT_LO: st_nxt.rdata = st_r.cnt[7:0];
                default: st_nxt.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            st_r <= '0;
            st_r.cnt <= FRT_RST_CNT;
            st_r.win_open <= 1'b1;
            st_r.pr <= FRT_RST_MASK2[FRT_PR_LSB +: 2];
            st_r.ctl_hi <= FRT_RST_TICK_CTL[FRT_CTL_HI_LSB +: 4];
            st_r.rtr <= FRT_RST_TICK_CTL[FRT_RTR_LSB +: 2];
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata_o = st_r.rdata;
    assign irq_o = st_r.irq;
    assign count_o = st_r.cnt;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    property p_wrap_set;
        !st_r.bypass && st_r.cnt == 16'hFFFF && cnt_adv |=> st_r.wrap_f && st_r.cnt == 16'h0000;
    endproperty
    a_wrap_set: assert property (p_wrap_set) else $error("wrap flag not set on rollover");

    property p_wrap_clear;
        wr_flag2 && reg_wdata_i[7] && !wrap_evt |=> !st_r.wrap_f;
    endproperty
    a_wrap_clear: assert property (p_wrap_clear) else $error("wrap flag not cleared");

    property p_zero_keeps;
        wr_flag2 && !reg_wdata_i[7] && st_r.wrap_f |=> st_r.wrap_f;
    endproperty
    a_zero_keeps: assert property (p_zero_keeps) else $error("zero write disturbed flag");

    property p_div16;
        !st_r.bypass && st_r.pr == 2'b11 && !wr_test |=> ##[0:15] cnt_adv;
    endproperty
    a_div16: assert property (p_div16) else $error("divide by 16 rate wrong");

    property p_div4_gap;
        !st_r.bypass && st_r.pr == 2'b01 && cnt_adv |=> !cnt_adv [*3];
    endproperty
    a_div4_gap: assert property (p_div4_gap) else $error("divide by 4 rate wrong");

    property p_pr_locked;
        !special_mode_i && !st_r.win_open |=> $stable(st_r.pr);
    endproperty
    a_pr_locked: assert property (p_pr_locked) else $error("prescale changed after window");

    property p_bypass_guard;
        !special_mode_i |=> $stable(st_r.bypass);
    endproperty
    a_bypass_guard: assert property (p_bypass_guard) else $error("bypass written in normal mode");

    property p_bypass_count;
        st_r.bypass && !wr_test |=> st_r.cnt[7:0] == $past(st_r.cnt[7:0]) + 8'h01;
    endproperty
    a_bypass_count: assert property (p_bypass_count) else $error("bypass count wrong");

    property p_tick_source;
        $rose(st_r.tick_f) |-> $past(&st_r.tap);
    endproperty
    a_tick_source: assert property (p_tick_source) else $error("tick flag set off the tap");

    property p_irq_level;
        ##1 irq_o == ((st_r.wrap_f && st_r.wrap_ie) || (st_r.tick_f && st_r.tick_ie));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt level mismatch");

    property p_ctl_zero;
        reg_rd_i && reg_addr_i == 3'h2 |=> reg_rdata_o[3:2] == 2'b00;
    endproperty
    a_ctl_zero: assert property (p_ctl_zero) else $error("reserved bits read nonzero");

    property p_tick_hold;
        st_r.tick_f && !(wr_flag2 && reg_wdata_i[6]) |=> st_r.tick_f;
    endproperty
    a_tick_hold: assert property (p_tick_hold) else $error("tick flag dropped by itself");

    property p_wrap_hold;
        st_r.wrap_f && !(wr_flag2 && reg_wdata_i[7]) |=> st_r.wrap_f;
    endproperty
    a_wrap_hold: assert property (p_wrap_hold) else $error("wrap flag dropped by itself");

    property p_tick_clear;
        wr_flag2 && reg_wdata_i[6] && !tick_evt |=> !st_r.tick_f;
    endproperty
    a_tick_clear: assert property (p_tick_clear) else $error("tick flag not cleared");

    property p_tick_zero_keeps;
        wr_flag2 && !reg_wdata_i[6] && st_r.tick_f |=> st_r.tick_f;
    endproperty
    a_tick_zero_keeps: assert property (p_tick_zero_keeps) else $error("zero write hit tick");

    property p_tick_set;
        tick_evt |=> st_r.tick_f;
    endproperty
    a_tick_set: assert property (p_tick_set) else $error("tick flag not set at period end");

    property p_wrap_evt_set;
        wrap_evt |=> st_r.wrap_f;
    endproperty
    a_wrap_evt_set: assert property (p_wrap_evt_set) else $error("wrap event lost");

    property p_cnt_runs;
        !st_r.bypass && cnt_adv |=> st_r.cnt == $past(st_r.cnt) + 16'h0001;
    endproperty
    a_cnt_runs: assert property (p_cnt_runs) else $error("counter did not advance");

    property p_cnt_hold;
        !st_r.bypass && !cnt_adv |=> $stable(st_r.cnt);
    endproperty
    a_cnt_hold: assert property (p_cnt_hold) else $error("counter moved between ticks");

    property p_div1;
        !st_r.bypass && st_r.pr == 2'b00 |-> cnt_adv;
    endproperty
    a_div1: assert property (p_div1) else $error("divide by 1 rate wrong");

    property p_div8_gap;
        !st_r.bypass && st_r.pr == 2'b10 && cnt_adv |=> !cnt_adv [*7];
    endproperty
    a_div8_gap: assert property (p_div8_gap) else $error("divide by 8 rate wrong");

    property p_tap_run;
        1'b1 |=> st_r.tap == $past(st_r.tap) + 13'h0001;
    endproperty
    a_tap_run: assert property (p_tap_run) else $error("tick source divider stalled");

    property p_tick_div_step;
        tap_evt |=> st_r.tick_div == $past(st_r.tick_div) + 3'h1;
    endproperty
    a_tick_div_step: assert property (p_tick_div_step) else $error("tick divider missed tap");

    property p_tick_div_hold;
        !tap_evt |=> $stable(st_r.tick_div);
    endproperty
    a_tick_div_hold: assert property (p_tick_div_hold) else $error("tick divider moved off tap");

    property p_tick_only_tap;
        !tap_evt && !st_r.tick_f |=> !st_r.tick_f;
    endproperty
    a_tick_only_tap: assert property (p_tick_only_tap) else $error("tick set between taps");

    property p_rate_write;
        wr_tick_ctl |=> st_r.rtr == $past(reg_wdata_i[1:0]);
    endproperty
    a_rate_write: assert property (p_rate_write) else $error("tick rate write lost");

    property p_irq_wrap;
        st_r.wrap_f && st_r.wrap_ie |-> irq_o;
    endproperty
    a_irq_wrap: assert property (p_irq_wrap) else $error("wrap interrupt missing");

    property p_irq_tick;
        st_r.tick_f && st_r.tick_ie |-> irq_o;
    endproperty
    a_irq_tick: assert property (p_irq_tick) else $error("tick interrupt missing");

    property p_irq_off;
        !(st_r.wrap_f && st_r.wrap_ie) && !(st_r.tick_f && st_r.tick_ie) |-> !irq_o;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupt without cause");

    property p_ie_write;
        wr_mask2 |=> st_r.wrap_ie == $past(reg_wdata_i[7]) && st_r.tick_ie == $past(reg_wdata_i[6]);
    endproperty
    a_ie_write: assert property (p_ie_write) else $error("enable write lost");

    property p_pr_once;
        !special_mode_i && st_r.pr_written |=> $stable(st_r.pr);
    endproperty
    a_pr_once: assert property (p_pr_once) else $error("second prescale write taken");

    property p_win_close;
        st_r.win_open && st_r.win == 7'h3F |=> !st_r.win_open;
    endproperty
    a_win_close: assert property (p_win_close) else $error("prescale window stayed open");

    property p_flag_read;
        reg_rd_i && reg_addr_i == 3'h1 |=>
            reg_rdata_o == {$past(st_r.wrap_f), $past(st_r.tick_f), 6'h00};
    endproperty
    a_flag_read: assert property (p_flag_read) else $error("flag read wrong");

    property p_cnt_read_hi;
        reg_rd_i && reg_addr_i == 3'h4 |=> reg_rdata_o == $past(st_r.cnt[15:8]);
    endproperty
    a_cnt_read_hi: assert property (p_cnt_read_hi) else $error("counter high read wrong");

    property p_bypass_hi;
        st_r.bypass && !wr_test |=> st_r.cnt[15:8] == $past(st_r.cnt[15:8]) + 8'h01;
    endproperty
    a_bypass_hi: assert property (p_bypass_hi) else $error("bypass high half wrong");

    property p_no_bypass_normal;
        !special_mode_i |-> !st_r.bypass;
    endproperty
    a_no_bypass_normal: assert property (p_no_bypass_normal) else $error("bypass in normal mode");
endmodule
`default_nettype wire

// >>> tb_free_running_timer_rti.sv
// self-checking bench for the free-running timer with periodic tick
`timescale 1ns/1ps
`default_nettype none
module tb_free_running_timer_rti;
    import frt_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic special_mode_i = 1'b0;
    logic [2:0] reg_addr_i = 3'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic irq_o;
    logic [15:0] count_o;
    logic [7:0] rd_val;
    logic [15:0] mark;
    int fail_count = 0;
    int cmp_count = 0;
    frt_timer dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .special_mode_i(special_mode_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .count_o(count_o));
    initial begin
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic do_reset(input logic mode);
        @(posedge clk_sys_i);
        rst_i <= 1'b1;
        special_mode_i <= mode;
        repeat (16) @(posedge clk_sys_i);
        rst_i <= 1'b0;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1;
        rd_val = reg_rdata_o;
    endtask
    // bounded wait for the interrupt level
    task automatic wait_irq(input logic lvl, input int limit);
        int n;
        n = 0;
        #1;
        while (irq_o !== lvl) begin
            @(posedge clk_sys_i);
            #1;
            n++;
            if (n > limit) begin
                chk({15'h0, irq_o}, {15'h0, lvl});
                fail_count++;
                wrap_up();
            end
        end
    endtask
    // count advance over 64 cycles
    task automatic span(input logic [15:0] exp);
        #1;
        mark = count_o;
        repeat (64) @(posedge clk_sys_i);
        #1;
        chk(count_o - mark, exp);
    endtask
    task automatic t_normal();
        wr(FRT_REG_MASK2, 8'h01);
        wr(FRT_REG_MASK2, 8'h03);
        rd(FRT_REG_MASK2);
        chk({8'h00, rd_val}, 16'h0001);
        span(16'h0010);
        wr(FRT_REG_TEST, 8'h01);
        rd(FRT_REG_TEST);
        chk({8'h00, rd_val}, 16'h0000);
        wr(FRT_REG_TICK_CTL, 8'hFF);
        rd(FRT_REG_TICK_CTL);
        chk({8'h00, rd_val}, 16'h00F3);
        rd(3'h7);
        chk({8'h00, rd_val}, 16'h0000);
        $display("normal mode test done");
    endtask
    task automatic t_special();
        rd(FRT_REG_TICK_CTL);
        chk({8'h00, rd_val}, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            wr(FRT_REG_MASK2, 8'(i));
            span(16'(64 >> (i == 0 ? 0 : i + 1)));
        end
        wr(FRT_REG_TEST, 8'h01);
        repeat (2) @(posedge clk_sys_i);
        #1;
        mark = count_o;
        @(posedge clk_sys_i);
        #1;
        chk(count_o, {mark[15:8] + 8'h01, mark[7:0] + 8'h01});
        $display("special mode test done");
    endtask
    task automatic t_tick();
        wr(FRT_REG_MASK2, 8'h40);
        wait_irq(1'b1, 9000);
        mark = count_o;
        rd(FRT_REG_FLAG2);
        chk({8'h00, rd_val}, 16'h0040);
        wr(FRT_REG_FLAG2, 8'h00);
        #1;
        chk({15'h0, irq_o}, 16'h0001);
        wr(FRT_REG_MASK2, 8'h00);
        wait_irq(1'b0, 3);
        rd(FRT_REG_FLAG2);
        chk({8'h00, rd_val}, 16'h0040);
        wr(FRT_REG_FLAG2, 8'h40);
        wr(FRT_REG_MASK2, 8'h40);
        #1;
        chk({15'h0, irq_o}, 16'h0000);
        wait_irq(1'b1, 8200);
        chk(count_o - mark, 16'h2000);
        wr(FRT_REG_FLAG2, 8'h40);
        $display("tick test done");
    endtask
    task automatic t_wrap();
        wr(FRT_REG_MASK2, 8'h80);
        wait_irq(1'b1, 60000);
        chk(count_o, 16'h0000);
        rd(FRT_REG_FLAG2);
        chk({8'h00, rd_val & 8'h80}, 16'h0080);
        mark = count_o;
        wr(FRT_REG_FLAG2, 8'h80);
        wait_irq(1'b0, 3);
        chk(count_o - mark, 16'h0002);
        $display("wrap test done");
    endtask
    task automatic t_rate();
        wr(FRT_REG_TICK_CTL, 8'h01);
        rd(FRT_REG_TICK_CTL);
        chk({8'h00, rd_val}, 16'h0001);
        wr(FRT_REG_FLAG2, 8'h40);
        wr(FRT_REG_MASK2, 8'h40);
        wait_irq(1'b1, 16400);
        mark = count_o;
        wr(FRT_REG_FLAG2, 8'h40);
        wait_irq(1'b0, 3);
        wait_irq(1'b1, 16400);
        chk(count_o - mark, 16'h4000);
        $display("tick rate test done");
    endtask
    initial begin
        do_reset(1'b0);
        t_normal();
        do_reset(1'b1);
        t_special();
        do_reset(1'b0);
        t_tick();
        t_wrap();
        t_rate();
        wrap_up();
    end
endmodule
`default_nettype wire
